// ===== logic/opsel_map.svh
`ifndef OPSEL_MAP_SVH
`define OPSEL_MAP_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OPSEL_ADDR_W        5
`define OPSEL_DATA_W        24
`define OPSEL_CFG_ADDR      5'h0f
`define OPSEL_STATUS_ADDR   5'h12

// ----------------------------------------------------------------
// configuration fields and reset value
// ----------------------------------------------------------------
`define OPSEL_CFG_RESET     24'h000001
`define OPSEL_SEL_MSB       4
`define OPSEL_SEL_LSB       0
`define OPSEL_TEST_BIT      5
`define OPSEL_FORCE_BIT     6
`define OPSEL_HOLD_BIT      7
`define OPSEL_PFET_BIT      8
`define OPSEL_NFET_BIT      9
`define OPSEL_CFG_USED_MSB  9

// ----------------------------------------------------------------
// status fields
// ----------------------------------------------------------------
`define OPSEL_STAT_SEL_BIT  0
`define OPSEL_STAT_LOCK_BIT 1

// ----------------------------------------------------------------
// selection codes with special meaning
// ----------------------------------------------------------------
`define OPSEL_CODE_TEST     5'h00
`define OPSEL_CODE_LOCK     5'h01
`define OPSEL_CODE_RSVD_A   5'h03
`define OPSEL_CODE_RSVD_B   5'h07
`define OPSEL_CODE_UNUSED_LO 5'h1a
`define OPSEL_CODE_UNUSED_HI 5'h1d
`define OPSEL_NUM_SRC       32

`endif

// ===== logic/opsel_pkg.sv
package opsel_pkg;

    typedef logic [4:0]  opsel_code_t;
    typedef logic [23:0] opsel_word_t;
    typedef logic [31:0] opsel_src_t;

    // who owns the shared pin
    typedef enum logic [2:0] {
        OPSEL_PIN_OFF  = 3'b001,
        OPSEL_PIN_READ = 3'b010,
        OPSEL_PIN_HOLD = 3'b100
    } opsel_pin_state_t;

endpackage : opsel_pkg

// ===== logic/opsel_sel_if.sv
`timescale 1ns/1ps
interface opsel_sel_if;
    import opsel_pkg::*;

    opsel_code_t code;
    logic        test_level;
    opsel_src_t  sources;
    logic        selected;

    modport ctrl (output code, output test_level, output sources,
                  input selected);
    modport mux  (input code, input test_level, input sources,
                  output selected);
endinterface : opsel_sel_if

// ===== logic/opsel_selector.sv
`timescale 1ns/1ps
`include "opsel_map.svh"

module opsel_selector (
    opsel_sel_if.mux sel
);
    import opsel_pkg::*;

    // reserved and unused codes deliver a quiet low level
    function automatic logic opsel_code_live(input opsel_code_t c);
        logic live;
        live = 1'b1;
        if (c == `OPSEL_CODE_RSVD_A || c == `OPSEL_CODE_RSVD_B)
            live = 1'b0;
        if (c >= `OPSEL_CODE_UNUSED_LO && c <= `OPSEL_CODE_UNUSED_HI)
            live = 1'b0;
        return live;
    endfunction : opsel_code_live

    always_comb begin
        if (sel.code == `OPSEL_CODE_TEST) begin
            sel.selected = sel.test_level;
        end else if (opsel_code_live(sel.code)) begin
            // sources are wired in code order, 1..25 except 3 and 7, 30, 31
            sel.selected = sel.sources[sel.code];
        end else begin
            sel.selected = 1'b0;
        end
    end

endmodule : opsel_selector

// ===== logic/opsel_pin_mux.sv
`timescale 1ns/1ps
`include "opsel_map.svh"
// Behaviour
// - after reset the pin driver is off except during reads sent here.
// - hold bit 7 keeps the pin driven, else it drives only in reads.
// - the host sets hold bit 7 to watch a signal, giving up sharing.
// - bits 4:0 pick the signal for the pin and reset to 1, lock.
// - code 0 puts the software test level of bit 5 on the pin.
// - codes 1 to 12, less reserved 3 and 7, route lock, window, slip pulls, refs and clocks.
// - codes 13 to 25 route aux serial, detector, strobes and resets.
// - codes 26 to 29 are unused, 30 is buffer enable, 31 soft reset.
// - force bit 6 shows only the signal, else read data is muxed in.
// - a read-only status word shows the signal in bit 0, lock in 1.

module opsel_pin_mux (
    // clock and reset
    input  wire logic                 core_clk_i,
    input  wire logic                 resetn_i,
    // register access from the serial port core
    input  wire logic                 reg_wr_i,
    input  wire logic [4:0]           reg_addr_i,
    input  wire opsel_pkg::opsel_word_t reg_wdata_i,
    output logic                      reg_rdata_valid_o,
    output opsel_pkg::opsel_word_t    reg_rdata_o,
    // serial read in progress, same clock
    input  wire logic                 spi_rd_active_i,
    input  wire logic                 spi_rd_data_i,
    // internal signals by code, asynchronous to this clock
    input  wire opsel_pkg::opsel_src_t sig_src_i,
    // shared pin
    output logic                      lock_readback_pin_o,
    output logic                      lock_readback_pin_oe_o,
    // driver trim bits
    output logic                      pullup_transistor_off_o,
    output logic                      pulldown_transistor_off_o
);
    import opsel_pkg::*;

    // ----------------------------------------------------------------
    // source synchronisers
    // ----------------------------------------------------------------
    opsel_src_t sync1_q;
    opsel_src_t sync2_q;
    opsel_src_t sync1_d;
    opsel_src_t sync2_d;

    // other clock domains: two flops before any logic sees a source
    // source 0 is never read: the test level stands in for it
    genvar gi;
    generate
        for (gi = 0; gi < `OPSEL_NUM_SRC; gi++) begin : g_sync
            always_comb begin
                sync1_d[gi] = sig_src_i[gi];
                sync2_d[gi] = sync1_q[gi];
            end
        end
    endgenerate

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
        end
    end

    // ----------------------------------------------------------------
    // configuration register
    // ----------------------------------------------------------------
    opsel_word_t cfg_q;
    opsel_word_t cfg_d;

    always_comb begin
        cfg_d = cfg_q;
        if (reg_wr_i && reg_addr_i == `OPSEL_CFG_ADDR)
            cfg_d = reg_wdata_i;
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i)
            cfg_q <= `OPSEL_CFG_RESET;
        else
            cfg_q <= cfg_d;
    end

    // bits 23:10 are kept only so that a read returns what was written
    logic cfg_force;
    logic cfg_hold;
    assign cfg_force = cfg_q[`OPSEL_FORCE_BIT];
    assign cfg_hold  = cfg_q[`OPSEL_HOLD_BIT];

    // ----------------------------------------------------------------
    // signal selection
    // ----------------------------------------------------------------
    opsel_sel_if sel_bus ();

    assign sel_bus.code       = cfg_q[`OPSEL_SEL_MSB:`OPSEL_SEL_LSB];
    assign sel_bus.test_level = cfg_q[`OPSEL_TEST_BIT];
    assign sel_bus.sources    = sync2_q;

    opsel_selector u_selector (
        .sel (sel_bus.mux)
    );

    // ----------------------------------------------------------------
    // pin ownership
    // ----------------------------------------------------------------
    opsel_pin_state_t pin_state_q;
    opsel_pin_state_t pin_state_d;
    logic             pin_q;
    logic             pin_d;
    logic             pin_oe_q;
    logic             pin_oe_d;

    always_comb begin
        case (pin_state_q)
            OPSEL_PIN_OFF, OPSEL_PIN_READ, OPSEL_PIN_HOLD: begin
                if (spi_rd_active_i)
                    pin_state_d = OPSEL_PIN_READ;
                else if (cfg_hold)
                    pin_state_d = OPSEL_PIN_HOLD;
                else
                    pin_state_d = OPSEL_PIN_OFF;
            end
            default: pin_state_d = OPSEL_PIN_OFF;
        endcase
    end

    always_comb begin
        pin_oe_d = (pin_state_d != OPSEL_PIN_OFF);
        // read data wins for the whole read unless forced off
        // data flop runs with the driver off: no stale bit when it turns on
        if (pin_state_d == OPSEL_PIN_READ && !cfg_force) begin
            pin_d = spi_rd_data_i;
        end else begin
            pin_d = sel_bus.selected;
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_state_q <= OPSEL_PIN_OFF;
            pin_q       <= 1'b0;
            pin_oe_q    <= 1'b0;
        end else begin
            pin_state_q <= pin_state_d;
            pin_q       <= pin_d;
            pin_oe_q    <= pin_oe_d;
        end
    end

    // ----------------------------------------------------------------
    // register read back
    // ----------------------------------------------------------------
    opsel_word_t rdata_q;
    opsel_word_t rdata_d;
    logic        rvalid_q;
    logic        rvalid_d;

    // status uses synced state only, so a read never sees a metastable bit
    always_comb begin
        rdata_d  = '0;
        rvalid_d = 1'b1;
        case (reg_addr_i)
            `OPSEL_CFG_ADDR: rdata_d = cfg_q;
            `OPSEL_STATUS_ADDR: begin
                rdata_d[`OPSEL_STAT_SEL_BIT]  = sel_bus.selected;
                rdata_d[`OPSEL_STAT_LOCK_BIT] =
                    sync2_q[`OPSEL_CODE_LOCK];
            end
            // other offsets belong to other blocks
            default: rvalid_d = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_q  <= '0;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    logic pfet_q;
    logic pfet_d;
    logic nfet_q;
    logic nfet_d;

    // taken from the next config value so trim and register change together
    always_comb begin
        pfet_d = cfg_d[`OPSEL_PFET_BIT];
        nfet_d = cfg_d[`OPSEL_NFET_BIT];
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pfet_q <= 1'b0;
            nfet_q <= 1'b0;
        end else begin
            pfet_q <= pfet_d;
            nfet_q <= nfet_d;
        end
    end

    assign lock_readback_pin_o       = pin_q;
    assign lock_readback_pin_oe_o    = pin_oe_q;
    assign reg_rdata_o               = rdata_q;
    assign reg_rdata_valid_o         = rvalid_q;
    assign pullup_transistor_off_o   = pfet_q;
    assign pulldown_transistor_off_o = nfet_q;

endmodule : opsel_pin_mux

// ===== verif/opsel_host_model.sv
`timescale 1ns/1ps
module opsel_host_model (
    // clock
    input  wire logic core_clk_i,
    // read frame toward the device
    output logic      rd_active_o,
    output logic      rd_data_o
);
    initial begin
        rd_active_o = 1'b0;
        rd_data_o   = 1'b0;
    end
    // msb first; line inverted after the frame so stale data never passes
    task automatic frame(input logic [15:0] bits, input int n);
        @(posedge core_clk_i) #1;
        rd_active_o = 1'b1;
        for (int i = n - 1; i >= 0; i--) begin
            rd_data_o = bits[i];
            @(posedge core_clk_i) #1;
        end
        rd_active_o = 1'b0;
        rd_data_o   = ~rd_data_o;
    endtask : frame
endmodule : opsel_host_model

// ===== verif/opsel_pin_mux_checker.sv
`timescale 1ns/1ps
`include "opsel_map.svh"
module opsel_pin_mux_checker (
    // clock and reset
    input wire logic                   core_clk_i,
    input wire logic                   resetn_i,
    // register port
    input wire logic                   reg_wr_i,
    input wire logic [4:0]             reg_addr_i,
    input wire opsel_pkg::opsel_word_t reg_wdata_i,
    input wire logic                   reg_rdata_valid_o,
    input wire opsel_pkg::opsel_word_t reg_rdata_o,
    // read and sources
    input wire logic                   spi_rd_active_i,
    input wire logic                   spi_rd_data_i,
    input wire opsel_pkg::opsel_src_t  sig_src_i,
    // pin and trim
    input wire logic                   lock_readback_pin_o,
    input wire logic                   lock_readback_pin_oe_o,
    input wire logic                   pullup_transistor_off_o,
    input wire logic                   pulldown_transistor_off_o
);
    import opsel_pkg::*;
    opsel_word_t cfg_q;
    opsel_word_t cfg_d;
    logic        exp_sel;
    always_comb begin
        cfg_d = cfg_q;
        if (reg_wr_i && reg_addr_i == `OPSEL_CFG_ADDR) cfg_d = reg_wdata_i;
    end
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) cfg_q <= `OPSEL_CFG_RESET;
        else cfg_q <= cfg_d;
    end
    always_comb begin
        case (cfg_q[4:0])
            5'h00: exp_sel = cfg_q[5];
            5'h03, 5'h07, 5'h1a, 5'h1b, 5'h1c, 5'h1d: exp_sel = 1'b0;
            default: exp_sel = sig_src_i[cfg_q[4:0]];
        endcase
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    // source path is two sync flops and the pin flop, so four quiet cycles settle the pin
    sequence quiet_s;
        (!spi_rd_active_i && !reg_wr_i && $stable(sig_src_i))[*4];
    endsequence
    oe_drive_a: assert property (lock_readback_pin_oe_o ==
        ($past(spi_rd_active_i) || $past(cfg_q[7]))) else $error("oe bad");
    hold_on_a: assert property (cfg_q[7] |=> lock_readback_pin_oe_o)
        else $error("hold lost");
    idle_off_a: assert property (!spi_rd_active_i && !cfg_q[7]
        |=> !lock_readback_pin_oe_o) else $error("idle drive");
    read_hold_a: assert property (spi_rd_active_i[*2]
        |=> lock_readback_pin_oe_o) else $error("read drop");
    read_data_a: assert property ($past(spi_rd_active_i)
        && !$past(cfg_q[6]) |-> lock_readback_pin_o == $past(spi_rd_data_i))
        else $error("read data");
    route_sel_a: assert property (
        quiet_s |-> lock_readback_pin_o == exp_sel) else $error("route bad");
    status_rd_a: assert property (quiet_s ##0
        (reg_addr_i == `OPSEL_STATUS_ADDR) |=> reg_rdata_valid_o &&
        reg_rdata_o == {22'h000000, $past(sig_src_i[1]), $past(exp_sel)})
        else $error("status bad");
    cfg_rd_a: assert property (
        reg_addr_i == `OPSEL_CFG_ADDR && !reg_wr_i
        |=> reg_rdata_o == $past(cfg_q)) else $error("cfg read");
endmodule : opsel_pin_mux_checker

bind opsel_pin_mux opsel_pin_mux_checker u_opsel_pin_mux_checker (
    .core_clk_i, .resetn_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i,
    .reg_rdata_valid_o, .reg_rdata_o, .spi_rd_active_i, .spi_rd_data_i,
    .sig_src_i, .lock_readback_pin_o, .lock_readback_pin_oe_o,
    .pullup_transistor_off_o, .pulldown_transistor_off_o);

// ===== verif/serial_out_pin_signal_mux_test.sv
`timescale 1ns/1ps
module serial_out_pin_signal_mux_test;
    import opsel_pkg::*;
    logic        core_clk_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic        reg_wr_i = 1'b0;
    logic [4:0]  reg_addr_i = 5'h00;
    opsel_word_t reg_wdata_i = 24'h000000;
    opsel_src_t  sig_src_i = 32'h00000000;
    logic        reg_rdata_valid_o, lock_readback_pin_o;
    logic        lock_readback_pin_oe_o;
    logic        pullup_transistor_off_o, pulldown_transistor_off_o;
    logic        spi_rd_active_i, spi_rd_data_i, v, exp;
    opsel_word_t reg_rdata_o, got;
    opsel_src_t  pat;
    int          mismatches = 0;
    int          n_tests = 0;
    int          cycles = 0;
    always #2.5 core_clk_i = ~core_clk_i;
    opsel_pin_mux u_opsel_pin_mux (.core_clk_i, .resetn_i, .reg_wr_i,
        .reg_addr_i, .reg_wdata_i, .reg_rdata_valid_o, .reg_rdata_o,
        .spi_rd_active_i, .spi_rd_data_i, .sig_src_i, .lock_readback_pin_o,
        .lock_readback_pin_oe_o, .pullup_transistor_off_o,
        .pulldown_transistor_off_o);
    opsel_host_model u_opsel_host_model (.core_clk_i,
        .rd_active_o(spi_rd_active_i), .rd_data_o(spi_rd_data_i));
    // ----------------------------------------------------------------
    // access and compare tasks
    // ----------------------------------------------------------------
    task automatic chk_word(input opsel_word_t g, input opsel_word_t e);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("Error at %0t: word %h expected %h", $time, g, e);
        end
    endtask : chk_word
    task automatic chk_bit(input logic g, input logic e);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("Error at %0t: bit %b expected %b", $time, g, e);
        end
    endtask : chk_bit
    task automatic wr(input logic [4:0] a, input opsel_word_t d);
        @(posedge core_clk_i) #1;
        reg_wr_i = 1'b1;
        reg_addr_i = a;
        reg_wdata_i = d;
        @(posedge core_clk_i) #1;
        reg_wr_i = 1'b0;
    endtask : wr
    task automatic rd(input logic [4:0] a);
        @(posedge core_clk_i) #1;
        reg_addr_i = a;
        @(posedge core_clk_i) #1;
        got = reg_rdata_o;
        v = reg_rdata_valid_o;
    endtask : rd
    task automatic settle();
        repeat (5) @(posedge core_clk_i);
        #1;
    endtask : settle
    // pin must be driven and show e five cycles into the 16-cycle frame
    task automatic read_check(input logic [15:0] b, input logic e);
        fork
            u_opsel_host_model.frame(b, 16);
            begin
                repeat (6) @(posedge core_clk_i);
                #2;
                chk_bit(lock_readback_pin_oe_o, 1'b1);
                chk_bit(lock_readback_pin_o, e);
            end
        join
    endtask : read_check
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            stop_test();
        end
    end
    initial begin
        repeat (4) @(posedge core_clk_i);
        #1 resetn_i = 1'b1;
        rd(5'h0f);
        chk_word(got, 24'h000001);
        chk_bit(v, 1'b1);
        chk_bit(pullup_transistor_off_o, 1'b0);
        chk_bit(pulldown_transistor_off_o, 1'b0);
        chk_bit(lock_readback_pin_oe_o, 1'b0);
        read_check(16'hffff, 1'b1);
        settle();
        chk_bit(lock_readback_pin_oe_o, 1'b0);
        chk_bit(lock_readback_pin_o, 1'b0);
        $display("test reset_and_read done");
        for (int c = 0; c < 32; c++) begin
            for (int p = 0; p < 2; p++) begin
                pat = p[0] ? 32'h5555aaaa : 32'haaaa5555;
                sig_src_i = pat;
                wr(5'h0f, {16'h0000, 1'b1, p[0], p[0], c[4:0]});
                settle();
                exp = (c == 0) ? p[0] :
                      (c inside {3, 7, [26:29]}) ? 1'b0 : pat[c];
                chk_bit(lock_readback_pin_o, exp);
                chk_bit(lock_readback_pin_oe_o, 1'b1);
                rd(5'h12);
                chk_word(got, {22'h000000, pat[1], exp});
            end
        end
        $display("test code_table done");
        wr(5'h12, 24'hffffff);
        wr(5'h05, 24'h000000);
        rd(5'h05);
        chk_bit(v, 1'b0);
        rd(5'h0f);
        chk_word(got, 24'h0000ff);
        wr(5'h0f, 24'h000341);
        sig_src_i = 32'h00000002;
        settle();
        chk_bit(pullup_transistor_off_o, 1'b1);
        chk_bit(pulldown_transistor_off_o, 1'b1);
        chk_bit(lock_readback_pin_oe_o, 1'b0);
        read_check(16'h0000, 1'b1);
        settle();
        chk_bit(lock_readback_pin_oe_o, 1'b0);
        $display("test force_and_refuse done");
        wr(5'h0f, 24'h000081);
        settle();
        chk_bit(pullup_transistor_off_o, 1'b0);
        chk_bit(lock_readback_pin_oe_o, 1'b1);
        chk_bit(lock_readback_pin_o, 1'b1);
        read_check(16'h0000, 1'b0);
        settle();
        chk_bit(lock_readback_pin_oe_o, 1'b1);
        chk_bit(lock_readback_pin_o, 1'b1);
        @(posedge core_clk_i) #1;
        resetn_i = 1'b0;
        repeat (2) @(posedge core_clk_i);
        #1;
        resetn_i = 1'b1;
        settle();
        chk_bit(lock_readback_pin_oe_o, 1'b0);
        chk_bit(lock_readback_pin_o, 1'b1);
        rd(5'h0f);
        chk_word(got, 24'h000001);
        chk_bit(v, 1'b1);
        $display("test hold_and_reset done");
        stop_test();
    end
endmodule : serial_out_pin_signal_mux_test
